// ===== modulo_timer_cfg.svh
// register offsets, field positions, reset values and timing counts of the modulo timer
`ifndef MODULO_TIMER_CFG_SVH
`define MODULO_TIMER_CFG_SVH
// -------------------------------------------------------------
// register byte offsets
// -------------------------------------------------------------
`define OFS_STATUS_CONTROL 8'h00
`define OFS_CLOCK_CONFIG 8'h04
`define OFS_CURRENT_COUNT 8'h08
`define OFS_MODULO_LIMIT 8'h0C
// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define POS_OVERFLOW_FLAG 7
`define POS_IRQ_ENABLE 6
`define POS_COUNTER_CLEAR 5
`define POS_COUNTER_HALT 4
`define POS_CLK_SRC_HI 5
`define POS_CLK_SRC_LO 4
`define POS_PRESCALE_HI 3
`define POS_PRESCALE_LO 0
// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define RST_COUNT 8'h00
`define RST_MODULO 8'h00
`define RST_CLK_SRC 2'h0
`define RST_PRESCALE 4'h0
`define RST_HALT 1'b1
// -------------------------------------------------------------
// timing counts
// -------------------------------------------------------------
`define PRESCALE_MAX_CODE 4'h8
`define SYNC_STAGES 2
`endif

// ===== modulo_timer_pkg.sv
// types shared by the modulo timer
package modulo_timer_pkg;
   typedef enum logic [1:0] {
      SRC_BUS, SRC_FIXED, SRC_PIN_FALL, SRC_PIN_RISE
   } clk_src_t;

   typedef enum logic [1:0] {
      PM_RUN, PM_WAIT, PM_STOP_SHALLOW, PM_STOP_DEEP
   } power_mode_t;

   typedef struct packed {
      logic overflow_irq_enable;
      logic counter_halt;
      clk_src_t clock_source_select;
      logic [3:0] prescale_select;
      logic [7:0] modulo_value;
   } timer_cfg_t;
endpackage

// ===== modulo_timer.sv
// modulo timer with prescaler, clock source select and ahb-lite register slave
`include "modulo_timer_cfg.svh"

module modulo_timer
   import modulo_timer_pkg::*;
#(
   parameter int CNT_W = 8,
   parameter int PRE_W = 8
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic fixed_freq_clock,
   input wire logic ext_timer_clock_pin,
   input wire power_mode_t power_mode,
   input wire logic deep_stop_wake,
   input wire logic debug_active,
   output logic overflow_irq,
   output logic overflow_flag
);
   // ----------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------
   // the register map and prescaler taps are fixed at these widths
   if (CNT_W != 8 || PRE_W != 8) begin : g_bad_width
      $error("modulo_timer: CNT_W and PRE_W must be 8");
   end

   // ----------------------------------------------------------
   // state
   // ----------------------------------------------------------
   timer_cfg_t cfg_r, cfg_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic [PRE_W-1:0] pre_r, pre_nxt;
   logic flag_r, flag_nxt;
   logic flag_armed_r, flag_armed_nxt;
   logic [1:0] pin_sync_r;
   logic pin_last_r, pin_last_nxt;
   logic fixed_last_r, fixed_last_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_addr_r, wr_addr_nxt;
   logic [31:0] hrdata_nxt;
   logic irq_nxt;

   // decode a word offset into a register select
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ----------------------------------------------------------
   // bus address phase
   // ----------------------------------------------------------
   logic addr_valid;
   logic [7:0] addr_lo;
   assign addr_valid = hsel && hready && htrans[1];
   assign addr_lo = haddr[7:0];

   // read value presented for each register
   function automatic logic [31:0] read_word(input logic [7:0] a, input timer_cfg_t c,
                                             input logic f, input logic [7:0] cnt);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (hit(a, `OFS_STATUS_CONTROL)) begin
         v[`POS_OVERFLOW_FLAG] = f;
         v[`POS_IRQ_ENABLE] = c.overflow_irq_enable;
         v[`POS_COUNTER_HALT] = c.counter_halt; // clear bit reads 0
      end else if (hit(a, `OFS_CLOCK_CONFIG)) begin
         v[`POS_CLK_SRC_HI:`POS_CLK_SRC_LO] = c.clock_source_select;
         v[`POS_PRESCALE_HI:`POS_PRESCALE_LO] = c.prescale_select;
      end else if (hit(a, `OFS_CURRENT_COUNT)) begin
         v[7:0] = cnt;
      end else if (hit(a, `OFS_MODULO_LIMIT)) begin
         v[7:0] = c.modulo_value;
      end
      return v; // unmapped reads as zero
   endfunction

   // ----------------------------------------------------------
   // source edge detection and prescaler tick
   // ----------------------------------------------------------
   logic pin_rise, pin_fall, fixed_rise, src_edge, pre_tick, run_en, wrap;
   logic [3:0] ps_eff;
   // only the second sync stage feeds edge logic
   assign pin_rise = pin_sync_r[1] && !pin_last_r;
   assign pin_fall = !pin_sync_r[1] && pin_last_r;
   assign fixed_rise = fixed_freq_clock && !fixed_last_r;
   // codes above 1000 saturate at divide by 256
   assign ps_eff = (cfg_r.prescale_select > `PRESCALE_MAX_CODE) ?
                   `PRESCALE_MAX_CODE : cfg_r.prescale_select;
   // debug, stop and halt all freeze the counter; wait keeps it running
   assign run_en = !cfg_r.counter_halt && !debug_active &&
                   (power_mode == PM_RUN || power_mode == PM_WAIT);

   always_comb begin
      case (cfg_r.clock_source_select)
         SRC_BUS: src_edge = 1'b1;
         SRC_FIXED: src_edge = fixed_rise;
         SRC_PIN_FALL: src_edge = pin_fall;
         SRC_PIN_RISE: src_edge = pin_rise;
         default: src_edge = 1'b1;
      endcase
   end

   // tick when the low ps_eff prescaler bits are all ones
   always_comb begin
      pre_tick = src_edge && run_en;
      for (int i = 0; i < PRE_W; i++) begin
         if (i < int'(ps_eff) && !pre_r[i]) begin
            pre_tick = 1'b0;
         end
      end
   end

   // free-run when modulo is zero, since FF == 0 - 1
   assign wrap = (cfg_r.modulo_value == 8'h00) ? (count_r == 8'hFF)
                                                : (count_r == cfg_r.modulo_value);

   // ----------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------
   // a write completes in the data phase following its address phase
   always_comb begin
      logic wr_sc, wr_clk, wr_mod, rd_sc, clear_req;
      logic [7:0] wd;
      wr_sc = 1'b0;
      wr_clk = 1'b0;
      wr_mod = 1'b0;
      rd_sc = 1'b0;
      clear_req = 1'b0;
      wd = hwdata[7:0];
      cfg_nxt = cfg_r;
      count_nxt = count_r;
      pre_nxt = pre_r;
      flag_nxt = flag_r;
      flag_armed_nxt = flag_armed_r;
      wr_pend_nxt = addr_valid && hwrite;
      wr_addr_nxt = addr_valid ? addr_lo : wr_addr_r;
      hrdata_nxt = hrdata;
      pin_last_nxt = pin_sync_r[1];
      fixed_last_nxt = fixed_freq_clock;

      if (addr_valid && !hwrite) begin
         hrdata_nxt = read_word(addr_lo, cfg_r, flag_r, count_r);
         rd_sc = hit(addr_lo, `OFS_STATUS_CONTROL);
      end
      if (wr_pend_r) begin
         wr_sc = hit(wr_addr_r, `OFS_STATUS_CONTROL);
         wr_clk = hit(wr_addr_r, `OFS_CLOCK_CONFIG);
         wr_mod = hit(wr_addr_r, `OFS_MODULO_LIMIT);
      end

      // control writes
      if (wr_sc) begin
         cfg_nxt.overflow_irq_enable = wd[`POS_IRQ_ENABLE];
         cfg_nxt.counter_halt = wd[`POS_COUNTER_HALT];
         clear_req = wd[`POS_COUNTER_CLEAR];
      end
      if (wr_clk) begin
         cfg_nxt.clock_source_select = clk_src_t'(wd[`POS_CLK_SRC_HI:`POS_CLK_SRC_LO]);
         cfg_nxt.prescale_select = wd[`POS_PRESCALE_HI:`POS_PRESCALE_LO];
      end
      if (wr_mod) begin
         cfg_nxt.modulo_value = wd;
         clear_req = 1'b1; // any modulo write resets the timer
      end

      // read of status with flag set arms the clear
      if (rd_sc && flag_r) begin
         flag_armed_nxt = 1'b1;
      end
      if (wr_sc && flag_armed_r && !wd[`POS_OVERFLOW_FLAG]) begin
         flag_nxt = 1'b0;
         flag_armed_nxt = 1'b0;
      end

      // counting: advance on tick, wrap past limit
      if (pre_tick) begin
         if (wrap) begin
            count_nxt = 8'h00;
         end else begin
            count_nxt = count_r + 8'h01;
         end
      end
      if (src_edge && run_en) begin
         pre_nxt = pre_r + 8'h01;
      end

      // clearing discards any held count and the flag
      if (clear_req) begin
         count_nxt = `RST_COUNT;
         pre_nxt = '0;
         flag_nxt = 1'b0;
         flag_armed_nxt = 1'b0;
      end
      // hardware set wins over any clear except a deep-stop wake in the same cycle, so no overflow is lost
      if (pre_tick && wrap) begin
         flag_nxt = 1'b1;
      end

      // shallow stop holds state; a deep-stop wake resets the config, count, prescaler and flag
      if (deep_stop_wake) begin
         cfg_nxt = '{overflow_irq_enable: 1'b0, counter_halt: `RST_HALT,
                     clock_source_select: clk_src_t'(`RST_CLK_SRC),
                     prescale_select: `RST_PRESCALE, modulo_value: `RST_MODULO};
         count_nxt = `RST_COUNT;
         pre_nxt = '0;
         flag_nxt = 1'b0;
         flag_armed_nxt = 1'b0;
      end
      // interrupt request only while enabled
      irq_nxt = flag_nxt && cfg_nxt.overflow_irq_enable;
   end

   // ----------------------------------------------------------
   // registers
   // ----------------------------------------------------------
   // pin synchroniser; pin is a plain input, so pwm timers may share it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_sync_r <= 2'h0;
      end else begin
         pin_sync_r <= {pin_sync_r[0], ext_timer_clock_pin};
      end
   end

   // reset sets halt so nothing counts until released
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_r <= '{overflow_irq_enable: 1'b0, counter_halt: `RST_HALT,
                    clock_source_select: SRC_BUS,
                    prescale_select: `RST_PRESCALE, modulo_value: `RST_MODULO};
         count_r <= `RST_COUNT;
         pre_r <= '0;
         flag_r <= 1'b0;
         flag_armed_r <= 1'b0;
         pin_last_r <= 1'b0;
         fixed_last_r <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         overflow_irq <= 1'b0;
         overflow_flag <= 1'b0;
      end else begin
         cfg_r <= cfg_nxt;
         count_r <= count_nxt;
         pre_r <= pre_nxt;
         flag_r <= flag_nxt;
         flag_armed_r <= flag_armed_nxt;
         pin_last_r <= pin_last_nxt;
         fixed_last_r <= fixed_last_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_addr_r <= wr_addr_nxt;
         hrdata <= hrdata_nxt;
         overflow_irq <= irq_nxt;
         overflow_flag <= flag_nxt;
      end
   end

   // zero-wait slave, always okay
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule

// ===== modulo_timer_sva.sv
// concurrent checks of the modulo timer bus slave and overflow outputs
module modulo_timer_sva
   import modulo_timer_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire power_mode_t power_mode,
   input wire logic deep_stop_wake,
   input wire logic debug_active,
   input wire logic overflow_irq,
   input wire logic overflow_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   // read address phase accepted at this edge
   wire logic rd_a = hsel & hready & htrans[1] & ~hwrite;

   // ------------------------------------------------
   // bus slave
   // ------------------------------------------------
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_upper_zero: assert property (rd_a |=> hrdata[31:8] == 24'h0)
      else $error("upper read bits set");
   a_status_holes: assert property (
      rd_a && haddr[7:0] == 8'h00 |=> !hrdata[5] && hrdata[3:0] == 4'h0)
      else $error("status unused bits set");
   a_cfg_holes: assert property (rd_a && haddr[7:0] == 8'h04 |=> hrdata[7:6] == 2'h0)
      else $error("clock config unused bits set");
   a_unmapped_zero: assert property (rd_a && haddr[7:0] == 8'h10 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");

   // ------------------------------------------------
   // overflow
   // ------------------------------------------------
   // margin of four cycles covers the sync and flag pipeline
   a_irq_needs_flag: assert property (overflow_irq |-> overflow_flag || $past(overflow_flag))
      else $error("irq without flag");
   a_stop_no_set: assert property (power_mode[1] [*4] |-> !$rose(overflow_flag))
      else $error("flag set in stop");
   a_debug_no_set: assert property (debug_active [*4] |-> !$rose(overflow_flag))
      else $error("flag set in debug");
   a_wake_clears: assert property (deep_stop_wake |-> ##[1:2] !overflow_flag && !overflow_irq)
      else $error("wake left flag set");

   c_flag_set: cover property ($rose(overflow_flag));
   c_irq_set: cover property ($rose(overflow_irq));
   c_wake_flag: cover property (deep_stop_wake && overflow_flag);
endmodule

// ===== test_modulo_timer.sv
// register level testbench of the modulo timer
module test_modulo_timer;
   import modulo_timer_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst_b, hsel, hwrite, fixed_freq_clock, ext_timer_clock_pin;
   logic deep_stop_wake, debug_active, hreadyout, hresp, overflow_irq, overflow_flag;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] rdat;
   power_mode_t power_mode;
   power_mode_t pm [4] = '{PM_RUN, PM_WAIT, PM_STOP_SHALLOW, PM_STOP_DEEP};
   int n_mismatch, cmp_count;

   // single slave, so its ready is the bus ready
   modulo_timer dut_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .fixed_freq_clock,
      .ext_timer_clock_pin, .power_mode, .deep_stop_wake, .debug_active,
      .overflow_irq, .overflow_flag);

   // 40 MHz bus clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task wrap_up;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one single word transfer; read data taken at the data phase end
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      int i;
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do begin
         @(posedge clk);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (i >= 20) begin
         n_mismatch++;
         $display("MISMATCH %0t bus timeout", $time);
         wrap_up();
      end
      rdat = hrdata[7:0];
   endtask

   task rd(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(rdat, e);
   endtask

   // toggles kept 4 cycles apart, well under a quarter of the bus rate
   task tog(input int n, input bit p);
      repeat (n) begin
         repeat (4) @(posedge clk);
         if (p)
            ext_timer_clock_pin <= ~ext_timer_clock_pin;
         else
            fixed_freq_clock <= ~fixed_freq_clock;
      end
      repeat (8) @(posedge clk);
   endtask

   // clear, configure, run over n toggles, then halt
   task run(input logic [1:0] s, input logic [3:0] c, input int n, input bit p);
      xfer(1'b1, 8'h00, 8'h30);
      xfer(1'b1, 8'h04, {2'h0, s, c});
      xfer(1'b1, 8'h00, 8'h00);
      tog(n, p);
      xfer(1'b1, 8'h00, 8'h10);
   endtask

   // flag outputs are registered copies, so let them settle
   task flags(input logic [7:0] e);
      repeat (3) @(posedge clk);
      chk({6'h0, overflow_irq, overflow_flag}, e);
   endtask

   // ------------------------------------------------
   // main sequence
   // ------------------------------------------------
   initial begin
      {hsel, hwrite, fixed_freq_clock, ext_timer_clock_pin} = 4'h0;
      {deep_stop_wake, debug_active} = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      power_mode = PM_RUN;
      rst_b = 1'b0;
      n_mismatch = 0;
      cmp_count = 0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rd(8'h00, 8'h10);
      rd(8'h04, 8'h00);
      rd(8'h0C, 8'h00);
      rd(8'h10, 8'h00);
      xfer(1'b1, 8'h08, 8'h55);
      rd(8'h08, 8'h00);
      // bus clock source at divide by 1 counts every edge from run release to halt write
      run(2'h0, 4'h0, 0, 1'b0);
      rd(8'h08, 8'h0A);
      // codes 9 and up must behave as divide by 256
      for (int c = 0; c < 10; c++) begin
         run(2'h1, c[3:0], 6 << (c > 8 ? 8 : c), 1'b0);
         rd(8'h08, 8'h03);
      end
      // seven toggles from low give four rises and three falls
      run(2'h3, 4'h0, 7, 1'b1);
      rd(8'h08, 8'h04);
      run(2'h2, 4'h0, 5, 1'b1);
      rd(8'h08, 8'h03);
      run(2'h1, 4'h0, 0, 1'b0);
      xfer(1'b1, 8'h00, 8'h00);
      // only the wait pass may count
      for (int i = 0; i < 4; i++) begin
         power_mode <= pm[i];
         debug_active <= (i == 0);
         tog(4, 1'b0);
      end
      power_mode <= PM_RUN;
      debug_active <= 1'b0;
      tog(4, 1'b0);
      xfer(1'b1, 8'h00, 8'h10);
      rd(8'h08, 8'h04);
      tog(4, 1'b0);
      rd(8'h08, 8'h04);
      xfer(1'b1, 8'h00, 8'h30);
      rd(8'h08, 8'h00);
      xfer(1'b1, 8'h0C, 8'h03);
      xfer(1'b1, 8'h00, 8'h40);
      tog(8, 1'b0);
      xfer(1'b1, 8'h00, 8'h50);
      flags(8'h03);
      rd(8'h08, 8'h00);
      rd(8'h00, 8'hD0);
      xfer(1'b1, 8'h00, 8'h10);
      flags(8'h00);
      xfer(1'b1, 8'h0C, 8'h00);
      xfer(1'b1, 8'h00, 8'h00);
      tog(512, 1'b0);
      xfer(1'b1, 8'h00, 8'h10);
      rd(8'h08, 8'h00);
      flags(8'h01);
      deep_stop_wake <= 1'b1;
      @(posedge clk);
      deep_stop_wake <= 1'b0;
      flags(8'h00);
      rd(8'h00, 8'h10);
      rd(8'h04, 8'h00);
      wrap_up();
   end
endmodule

bind modulo_timer modulo_timer_sva chk_u (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hrdata, .hreadyout, .hresp, .power_mode, .deep_stop_wake, .debug_active,
   .overflow_irq, .overflow_flag);
